// ### rtl/lzcs_counter.sv
// Combinational leading zero counter.
`timescale 1ns/1ps
module lzcs_counter
  import lzcs_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Operand.
  input wire logic [WIDTH-1:0] value_i,
  // Count of leading zero bits.
  output logic [5:0] count_o
);

  // ==========================================================================
  // Priority scan from the least significant bit upwards, so the highest
  // set bit is the last one to set the count.
  always_comb begin
    count_o = ALL_ZERO_COUNT; // see [RQ3]
    for (int i = 0; i < WIDTH; i++) begin
      if (value_i[i]) begin
        count_o = 6'(WIDTH - 1 - i); // see [RQ2]
      end
    end
  end

endmodule : lzcs_counter

// ### rtl/lzcs_pkg.sv
// Package with constants and types for the leading zero count datapath.
// How it works
// [RQ1] Decode the count opcode; destination in 15:12, source in 3:0, 0001 in 7:4.
// [RQ2] Write the count of leading zero bits of the source into the destination.
// [RQ3] An all-zero source gives 32; a set top bit gives 0.
// [RQ4] Execute only when the condition field in 31:28 passes against the flags.
// [RQ5] Naming the program counter as source or destination gives no defined result.
// [RQ6] Undefined operand cases still complete in one cycle without any stall.
// [RQ7] The instruction producer keeps zero-required fields at zero.
// [RQ8] Clamp negative overflow to 0x80000000 and positive overflow to 0x7FFFFFFF.
// [RQ9] The clamp-detect flag is 1 exactly when clamping to 32 bits is needed.
// [RQ10] The widening helper copies the operand's top bit into all higher bits.
// [RQ11] Halfword select takes the top 16 bits for top, bottom 16 for bottom.
package lzcs_pkg;

  // ==========================================================================
  // Instruction fields.
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int DST_HI = 15;
  localparam int DST_LO = 12;
  localparam int SRC_HI = 3;
  localparam int SRC_LO = 0;
  localparam logic [31:0] OP_MASK = 32'h0FF000F0;
  localparam logic [31:0] OP_MATCH = 32'h01600010;
  localparam logic [31:0] ZERO_REQ_MASK = 32'h000F0F00;
  localparam logic [3:0] PC_INDEX = 4'hF;
  localparam logic [31:0] CLAMP_NEG = 32'h80000000;
  localparam logic [31:0] CLAMP_POS = 32'h7FFFFFFF;
  localparam logic [5:0] ALL_ZERO_COUNT = 6'h20;

  // Condition codes.
  localparam logic [3:0] CC_EQ = 4'h0;
  localparam logic [3:0] CC_NE = 4'h1;
  localparam logic [3:0] CC_CS = 4'h2;
  localparam logic [3:0] CC_CC = 4'h3;
  localparam logic [3:0] CC_MI = 4'h4;
  localparam logic [3:0] CC_PL = 4'h5;
  localparam logic [3:0] CC_VS = 4'h6;
  localparam logic [3:0] CC_VC = 4'h7;
  localparam logic [3:0] CC_HI = 4'h8;
  localparam logic [3:0] CC_LS = 4'h9;
  localparam logic [3:0] CC_GE = 4'hA;
  localparam logic [3:0] CC_LT = 4'hB;
  localparam logic [3:0] CC_GT = 4'hC;
  localparam logic [3:0] CC_LE = 4'hD;
  localparam logic [3:0] CC_AL = 4'hE;

  // ==========================================================================
  // Flags in N, Z, C, V order.
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } lzcs_flags_type;

  // Register write-back carrier.
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [31:0] data;
    logic pc_hazard;
  } lzcs_wb_type;

  typedef enum logic [1:0] {
    LZCS_HALF_BOTTOM,
    LZCS_HALF_TOP
  } lzcs_half_type;

endpackage : lzcs_pkg

// ### rtl/lzcs_unit.sv
// Leading zero count execute unit with saturation helpers.
`timescale 1ns/1ps
module lzcs_unit
  import lzcs_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Instruction issue.
  input wire logic issue_i,
  input wire logic [31:0] instr_i,
  input wire lzcs_flags_type flags_i,
  input wire logic [31:0] source_reg_index_data_i,
  // Saturation helper operands.
  input wire logic [63:0] wide_result_i,
  input wire logic [15:0] narrow_i,
  input wire logic [31:0] half_src_i,
  input wire lzcs_half_type half_sel_i,
  // Write-back.
  output lzcs_wb_type wb_o,
  output logic leading_zero_count_op_o,
  output logic zero_required_field_bad_o,
  // Helper results.
  output logic [31:0] clamp_to_word_o,
  output logic clamp_detect_o,
  output logic [31:0] widen_signed_o,
  output logic [31:0] half_o
);

  // ==========================================================================
  // Condition evaluation.
  function automatic logic cond_pass(input logic [3:0] cc,
                                     input lzcs_flags_type f);
    case (cc)
      CC_EQ: cond_pass = f.z;
      CC_NE: cond_pass = !f.z;
      CC_CS: cond_pass = f.c;
      CC_CC: cond_pass = !f.c;
      CC_MI: cond_pass = f.n;
      CC_PL: cond_pass = !f.n;
      CC_VS: cond_pass = f.v;
      CC_VC: cond_pass = !f.v;
      CC_HI: cond_pass = f.c && !f.z;
      CC_LS: cond_pass = !f.c || f.z;
      CC_GE: cond_pass = f.n == f.v;
      CC_LT: cond_pass = f.n != f.v;
      CC_GT: cond_pass = !f.z && (f.n == f.v);
      CC_LE: cond_pass = f.z || (f.n != f.v);
      CC_AL: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction : cond_pass

  // ==========================================================================
  // Register index checks.
  function automatic logic names_pc(input logic [3:0] idx);
    names_pc = (idx == PC_INDEX); // see [RQ5]
  endfunction : names_pc

  // ==========================================================================
  // Decode.
  wire logic is_lzc = (instr_i & OP_MASK) == OP_MATCH; // see [RQ1]
  wire logic [3:0] dst_idx = instr_i[DST_HI:DST_LO]; // see [RQ1]
  wire logic [3:0] src_idx = instr_i[SRC_HI:SRC_LO]; // see [RQ1]
  wire logic passes = cond_pass(instr_i[COND_HI:COND_LO], flags_i);
  wire logic exec = issue_i && is_lzc && passes; // see [RQ4]
  // Program counter operands only raise a flag; the count still completes.
  wire logic pc_used = names_pc(dst_idx) || names_pc(src_idx);
  wire logic zr_bad = issue_i && is_lzc &&
                      ((instr_i & ZERO_REQ_MASK) != 32'h00000000);
  wire logic [5:0] count;

  lzcs_counter #(
    .WIDTH(32)
  ) u_counter (
    .value_i(source_reg_index_data_i),
    .count_o(count)
  );

  // ==========================================================================
  // Saturation helpers.
  wire logic upper_same = (wide_result_i[63:31] == {33{1'b0}}) ||
                          (wide_result_i[63:31] == {33{1'b1}});
  wire logic sat_needed = !upper_same; // see [RQ9]
  wire logic [31:0] sat_val = sat_needed ?
    (wide_result_i[63] ? CLAMP_NEG : CLAMP_POS) :
    wide_result_i[31:0]; // see [RQ8]
  wire logic [31:0] widened = {{16{narrow_i[15]}}, narrow_i}; // see [RQ10]
  wire logic [31:0] half_pick = (half_sel_i == LZCS_HALF_TOP) ?
    {16'h0000, half_src_i[31:16]} :
    {16'h0000, half_src_i[15:0]}; // see [RQ11]

  lzcs_wb_type wb_d;
  always_comb begin
    wb_d = '0;
    wb_d.valid = exec; // see [RQ4]
    wb_d.index = dst_idx;
    wb_d.data = {26'h0000000, count}; // see [RQ2]
    wb_d.pc_hazard = exec && pc_used; // see [RQ5]
  end

  // Single-cycle result: no state machine can hang on any encoding.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin // see [RQ6]
    if (rst_i) begin
      wb_o <= '0;
    end else begin
      wb_o <= wb_d;
    end
  end

  // Status flags that report how the issued word decoded.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      leading_zero_count_op_o <= 1'b0;
      zero_required_field_bad_o <= 1'b0;
    end else begin
      leading_zero_count_op_o <= issue_i && is_lzc;
      zero_required_field_bad_o <= zr_bad; // see [RQ7]
    end
  end

  // Helper results are recomputed every cycle, whether or not an
  // instruction is issued.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clamp_to_word_o <= 32'h00000000;
      clamp_detect_o <= 1'b0;
      widen_signed_o <= 32'h00000000;
      half_o <= 32'h00000000;
    end else begin
      clamp_to_word_o <= sat_val;
      clamp_detect_o <= sat_needed;
      widen_signed_o <= widened;
      half_o <= half_pick;
    end
  end

  // ==========================================================================
  // Assertions on decode and write-back.
  a_skip_failed_cond: assert property ( // see [RQ4]
    @(posedge sys_clk_i) disable iff (rst_i) !passes |=> !wb_o.valid)
    else $error("write-back despite failed condition");
  a_no_match: assert property ( // see [RQ1]
    @(posedge sys_clk_i) disable iff (rst_i)
    issue_i && instr_i[7:4] != 4'h1 |=> !wb_o.valid &&
      !leading_zero_count_op_o)
    else $error("write-back for a word that is not the count op");
  a_op_flag: assert property ( // see [RQ1]
    @(posedge sys_clk_i) disable iff (rst_i)
    issue_i && instr_i[27:20] == 8'h16 && instr_i[7:4] == 4'h1 |=>
      leading_zero_count_op_o)
    else $error("count op not recognised");
  a_count_zero: assert property ( // see [RQ3]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && source_reg_index_data_i == 32'h0 |=> wb_o.data == 32'h20)
    else $error("zero source did not count 32");
  a_count_msb: assert property ( // see [RQ3]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && source_reg_index_data_i[31] |=> wb_o.data == 32'h0)
    else $error("top bit set did not count 0");
  a_count_value: assert property ( // see [RQ2]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && source_reg_index_data_i != 32'h0 |=>
      $past(source_reg_index_data_i) >> (31 - wb_o.data[4:0]) == 32'h1)
    else $error("leading zero count wrong");
  a_data_upper: assert property ( // see [RQ2]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec |=> wb_o.data[31:6] == 26'h0000000)
    else $error("count has bits above its width");
  a_dest_index: assert property ( // see [RQ1]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec |=> wb_o.valid && wb_o.index == $past(instr_i[15:12]))
    else $error("destination index wrong");
  a_no_stall: assert property ( // see [RQ6]
    @(posedge sys_clk_i) disable iff (rst_i)
    issue_i && is_lzc && passes && pc_used |=>
      wb_o.valid && wb_o.pc_hazard)
    else $error("program counter case did not complete");
  a_pc_source: assert property ( // see [RQ5]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && instr_i[3:0] == 4'hF |=> wb_o.pc_hazard)
    else $error("program counter source not flagged");
  a_pc_clear: assert property ( // see [RQ5]
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && instr_i[15:12] != 4'hF && instr_i[3:0] != 4'hF |=>
      !wb_o.pc_hazard)
    else $error("hazard flagged without program counter");
  a_zero_field: assert property ( // see [RQ7]
    @(posedge sys_clk_i) disable iff (rst_i)
    issue_i && is_lzc && (instr_i[19:16] != 4'h0 || instr_i[11:8] != 4'h0)
      |=> zero_required_field_bad_o)
    else $error("nonzero zero-required field not flagged");

  // ==========================================================================
  // Assertions on the saturation helpers.
  a_clamp_value: assert property ( // see [RQ8]
    @(posedge sys_clk_i) disable iff (rst_i)
    $signed(wide_result_i) > 64'sh7FFFFFFF |=> clamp_to_word_o == 32'h7FFFFFFF)
    else $error("positive clamp wrong");
  a_clamp_neg: assert property ( // see [RQ8]
    @(posedge sys_clk_i) disable iff (rst_i)
    $signed(wide_result_i) < -64'sh80000000 |=> clamp_to_word_o == 32'h80000000)
    else $error("negative clamp wrong");
  a_clamp_detect: assert property ( // see [RQ9]
    @(posedge sys_clk_i) disable iff (rst_i)
    ($signed(wide_result_i) > 64'sh7FFFFFFF ||
     $signed(wide_result_i) < -64'sh80000000) |=> clamp_detect_o)
    else $error("clamp detect missed");
  a_clamp_pass: assert property ( // see [RQ8] [RQ9]
    @(posedge sys_clk_i) disable iff (rst_i)
    ($signed(wide_result_i) <= 64'sh7FFFFFFF &&
     $signed(wide_result_i) >= -64'sh80000000) |=>
      !clamp_detect_o && clamp_to_word_o == $past(wide_result_i[31:0]))
    else $error("in-range result was altered");
  a_widen_top: assert property ( // see [RQ10]
    @(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> widen_signed_o[31:16] == {16{$past(narrow_i[15])}})
    else $error("sign extension wrong");
  a_widen_low: assert property ( // see [RQ10]
    @(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> widen_signed_o[15:0] == $past(narrow_i))
    else $error("widened operand lost its low bits");
  a_half_pick: assert property ( // see [RQ11]
    @(posedge sys_clk_i) disable iff (rst_i)
    half_sel_i == LZCS_HALF_TOP |=>
      half_o[15:0] == $past(half_src_i[31:16]))
    else $error("top halfword wrong");
  a_half_bottom: assert property ( // see [RQ11]
    @(posedge sys_clk_i) disable iff (rst_i)
    half_sel_i == LZCS_HALF_BOTTOM |=>
      half_o[15:0] == $past(half_src_i[15:0]))
    else $error("bottom halfword wrong");
  a_half_upper: assert property ( // see [RQ11]
    @(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> half_o[31:16] == 16'h0000)
    else $error("selected halfword not zero-extended");

  // ==========================================================================
  // Main scenarios.
  c_exec_count: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    exec ##1 wb_o.valid);
  c_cond_fail: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    issue_i && is_lzc && !passes);
  c_clamp: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    sat_needed);
  c_pc_hazard: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    wb_o.pc_hazard);
  c_zero_field: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    zero_required_field_bad_o);

endmodule : lzcs_unit

// ### tb/testbench.sv
// Self-checking testbench for the leading zero count execute unit.
`timescale 1ns/1ps
module testbench;
  import lzcs_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic issue_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  lzcs_flags_type flags_i = '0;
  logic [31:0] src_q = 32'h0;
  logic [63:0] wide_i = 64'h0;
  logic [15:0] narrow_i = 16'h0;
  logic [31:0] half_src_i = 32'h0;
  lzcs_half_type half_sel_i = LZCS_HALF_BOTTOM;
  lzcs_wb_type wb_o;
  logic op_o, bad_o, det_o;
  logic [31:0] clamp_o, widen_o, half_o;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  lzcs_unit lzcs_unit_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .issue_i(issue_i), .instr_i(instr_i), .flags_i(flags_i),
    .source_reg_index_data_i(src_q), .wide_result_i(wide_i),
    .narrow_i(narrow_i), .half_src_i(half_src_i), .half_sel_i(half_sel_i),
    .wb_o(wb_o), .leading_zero_count_op_o(op_o),
    .zero_required_field_bad_o(bad_o), .clamp_to_word_o(clamp_o),
    .clamp_detect_o(det_o), .widen_signed_o(widen_o), .half_o(half_o));

  always #5 sys_clk_i = ~sys_clk_i;

  // ==========================================================================
  // A hung run is cut short well beyond the expected length.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [37:0] seen,
                     input logic [37:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] mk(input logic [3:0] c, input logic [3:0] d,
                                     input logic [3:0] s);
    return {c, 8'h16, 4'h0, d, 4'h0, 4'h1, s};
  endfunction : mk

  // Starts on a fresh falling edge so the strobe is never dropped and
  // raised in one step; results stand after the next rise.
  task automatic issue(input logic [31:0] w, input logic [31:0] v);
    @(negedge sys_clk_i);
    issue_i = 1'b1;
    instr_i = w;
    src_q = v;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    issue_i = 1'b0;
  endtask : issue

  // ==========================================================================
  task automatic t_count;
    logic [31:0] v [5] = '{32'h0, 32'h80000000, 32'h0000FFFF, 32'h1, 32'h400};
    logic [5:0] n [5] = '{6'h20, 6'h0, 6'h10, 6'h1F, 6'h15};
    for (int i = 0; i < 5; i++) begin
      issue(mk(CC_AL, i[3:0], 4'h2), v[i]);
      chk("wb", wb_o, {1'b1, i[3:0], 26'h0, n[i], 1'b0});
      chk("op", op_o, 38'h1);
      chk("bad", bad_o, 38'h0);
    end
  endtask : t_count

  task automatic t_cond;
    flags_i = '{n: 1'b0, z: 1'b0, c: 1'b0, v: 1'b0};
    issue(mk(CC_EQ, 4'h3, 4'h1), 32'h1);
    chk("eq fail", {op_o, wb_o.valid}, 38'h2);
    issue(mk(CC_NE, 4'h3, 4'h1), 32'h1);
    chk("ne pass", wb_o.valid, 38'h1);
    issue(mk(4'hF, 4'h3, 4'h1), 32'h1);
    chk("never", wb_o.valid, 38'h0);
    flags_i = '{n: 1'b1, z: 1'b0, c: 1'b0, v: 1'b0};
    issue(mk(CC_GE, 4'h3, 4'h1), 32'h1);
    chk("ge fail", wb_o.valid, 38'h0);
    issue(mk(CC_LT, 4'h3, 4'h1), 32'h1);
    chk("lt pass", wb_o.valid, 38'h1);
  endtask : t_cond

  task automatic t_odd;
    issue(mk(CC_AL, 4'h1, 4'h1) & ~32'h10, 32'h1);
    chk("no match", {op_o, wb_o.valid}, 38'h0);
    issue(mk(CC_AL, 4'hF, 4'hF), 32'h00010000);
    chk("pc", wb_o, {1'b1, 4'hF, 32'hF, 1'b1});
    issue(mk(CC_AL, 4'h1, 4'h1) | 32'h000F0000, 32'h1);
    chk("sbz", bad_o, 38'h1);
  endtask : t_odd

  task automatic t_helpers;
    logic [63:0] w [5] = '{64'h80000000, 64'hFFFFFFFF7FFFFFFF,
      64'h7FFFFFFF, 64'hFFFFFFFF80000000, 64'h12};
    logic [32:0] e [5] = '{{1'b1, CLAMP_POS}, {1'b1, CLAMP_NEG},
      {1'b0, CLAMP_POS}, {1'b0, CLAMP_NEG}, 33'h12};
    for (int i = 0; i < 5; i++) begin
      wide_i = w[i];
      narrow_i = i[0] ? 16'h8001 : 16'h7FFE;
      half_src_i = 32'hA5C3_1E2D;
      half_sel_i = i[0] ? LZCS_HALF_TOP : LZCS_HALF_BOTTOM;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("clamp", {det_o, clamp_o}, e[i]);
      chk("widen", widen_o, i[0] ? 38'hFFFF8001 : 38'h7FFE);
      chk("half", half_o, i[0] ? 38'hA5C3 : 38'h1E2D);
    end
  endtask : t_helpers

  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_count();
    t_cond();
    t_odd();
    t_helpers();
    report_and_stop();
  end
endmodule : testbench
